/* File: dv/imtrs_slave_model.sv */
// Behavioural slave device on the two-wire bus, answering one address.
`timescale 1ns/100ps
module imtrs_slave_model #(
    parameter logic [6:0] ADDR = 7'h5A,
    parameter logic [7:0] TXB  = 8'hA5,
    parameter logic [7:0] NAKB = 8'h3C
) (
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sdaOeN,
    output logic [7:0]      rxByte
);
    logic [7:0] sh;
    logic       act;
    logic       rd;
    logic       isAddr;
    logic       mNack;
    int         n;

    // Start released and not addressed.
    initial begin
        sdaOeN = 1'h1;
        rxByte = 8'h00;
        sh = 8'h00;
        act = 1'h0;
        n = 0;
    end

    // Data edges while the clock is high frame a transfer.
    always @(sda) begin
        if (scl) begin
            act = ~sda;
            isAddr = 1'h1;
            rd = 1'h0;
            n = 0;
            sdaOeN = 1'h1;
        end
    end

    // Bits are sampled on the rising clock, the acknowledge as the ninth.
    always @(posedge scl) begin
        if (act) begin
            if (n < 8) sh = {sh[6:0], sda};
            else mNack = sda;
            n++;
        end
    end

    // The line only changes while the clock is low, so it never fakes a frame.
    always @(negedge scl) begin
        if (act && n == 8) begin
            if (isAddr && sh[7:1] != ADDR) act = 1'h0;
            else begin
                if (isAddr) rd = sh[0];
                else if (!rd) rxByte = sh;
                sdaOeN = !isAddr && (rd || sh == NAKB);
            end
        end else if (act && n == 9) begin
            n = 0;
            isAddr = 1'h0;
            sdaOeN = (rd && !mNack) ? TXB[7] : 1'h1;
            if (rd && mNack) act = 1'h0;
        end else if (act && rd && !isAddr) begin
            sdaOeN = TXB[7 - n];
        end
    end
endmodule : imtrs_slave_model

/* File: dv/imtrs_top_test.sv */
// Self-checking bench of the two-wire master sequencer.
`timescale 1ns/100ps
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module imtrs_top_test;
    localparam logic [6:0] SLV = 7'h5A;
    logic        clk_sys, reset, avsRead, avsWrite, avsWaitrequest;
    logic        sclOeN, sdaOeN, slvOeN, sclDrv, sdaDrv, arbPull;
    logic [3:0]  avsByteenable;
    logic [3:0]  avsAddress;
    logic [31:0] avsWritedata, avsReaddata;
    logic [7:0]  rxByte;
    int          mismatches = 0;
    int          numChecks = 0;
    // Open-drain lines: a low enable drives the pin value, otherwise the pull-up wins.
    // The arbPull signal stands in for a second master that holds the data line low.
    wire logic   sclLine = sclOeN | sclDrv;
    wire logic   sdaLine = (sdaOeN | sdaDrv) & slvOeN & ~arbPull;

    imtrs_top i_imtrs_top (.clk_sys(clk_sys), .reset(reset), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .sclIn(sclLine), .sclOut(sclDrv), .sclOeN(sclOeN),
        .sdaIn(sdaLine), .sdaOut(sdaDrv), .sdaOeN(sdaOeN));
    imtrs_slave_model i_imtrs_slave_model (.scl(sclLine), .sda(sdaLine),
        .sdaOeN(slvOeN), .rxByte(rxByte));

    // System clock, 25 ns period.
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // One bus transfer; waitrequest and read data are taken at the same rising edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int t;
        t = 0;
        @(posedge clk_sys);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWritedata <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            t++;
        end while (avsWaitrequest !== 1'h0 && t < 100);
        q = avsReaddata[7:0];
        avsWrite <= 1'h0;
        avsRead <= 1'h0;
        if (t >= 100) `CHK(avsWaitrequest, 1'h0)
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'h1, a, d, q);
    endtask : wr

    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'h0, a, 8'h00, q);
        `CHK(q, e)
        `CHK(avsReaddata[31:8], 24'h000000)
    endtask : rdChk

    // Kick the sequencer, poll for the done flag, then judge the status.
    task automatic step(input logic [7:0] c, input logic [7:0] st);
        logic [7:0] q;
        int t;
        wr(imtrs_pkg::OFF_CTRL, c);
        t = 0;
        do begin
            bus(1'h0, imtrs_pkg::OFF_CTRL, 8'h00, q);
            t++;
        end while (q[7] !== 1'h1 && t < 4000);
        if (t >= 4000) `CHK(q[7], 1'h1)
        rdChk(imtrs_pkg::OFF_STAT, st);
    endtask : step

    task automatic testReset();
        rdChk(imtrs_pkg::OFF_CTRL, 8'h00);
        rdChk(imtrs_pkg::OFF_DATA, imtrs_pkg::DATA_RESET);
        rdChk(4'hC, 8'h00);
        // Lane 0 disabled, so the write must leave the prescaler bits alone.
        avsByteenable <= 4'hE;
        wr(imtrs_pkg::OFF_STAT, 8'h03);
        avsByteenable <= 4'hF;
        rdChk(imtrs_pkg::OFF_STAT, imtrs_pkg::STAT_NONE);
        wr(imtrs_pkg::OFF_STAT, 8'h03);
        rdChk(imtrs_pkg::OFF_STAT, 8'hFB);
        wr(imtrs_pkg::OFF_STAT, 8'h00);
        rdChk(imtrs_pkg::OFF_STAT, imtrs_pkg::STAT_NONE);
        wr(imtrs_pkg::OFF_DATA, 8'h12);
        rdChk(imtrs_pkg::OFF_CTRL, 8'h08);
        rdChk(imtrs_pkg::OFF_DATA, imtrs_pkg::DATA_RESET);
        $display("test reset done");
    endtask : testReset

    task automatic testReceive();
        step(8'hA4, imtrs_pkg::STAT_START);
        repeat (300) @(posedge clk_sys);
        `CHK(sclOeN, 1'h0)
        rdChk(imtrs_pkg::OFF_CTRL, 8'hAC);
        wr(imtrs_pkg::OFF_DATA, {SLV, 1'h1});
        rdChk(imtrs_pkg::OFF_CTRL, 8'hA4);
        step(8'hC4, imtrs_pkg::STAT_RADDR_ACK);
        step(8'hC4, imtrs_pkg::STAT_RXD_ACK);
        rdChk(imtrs_pkg::OFF_DATA, 8'hA5);
        step(8'h84, imtrs_pkg::STAT_RXD_NACK);
        rdChk(imtrs_pkg::OFF_DATA, 8'hA5);
        step(8'hA4, imtrs_pkg::STAT_REP_START);
        $display("test receive done");
    endtask : testReceive

    task automatic testTransmit();
        wr(imtrs_pkg::OFF_DATA, {SLV, 1'h0});
        step(8'h84, imtrs_pkg::STAT_WADDR_ACK);
        wr(imtrs_pkg::OFF_DATA, 8'h3C);
        step(8'h84, imtrs_pkg::STAT_TXD_NACK);
        wr(imtrs_pkg::OFF_DATA, 8'h96);
        step(8'h84, imtrs_pkg::STAT_TXD_ACK);
        `CHK(rxByte, 8'h96)
        wr(imtrs_pkg::OFF_DATA, 8'h3C);
        step(8'h84, imtrs_pkg::STAT_TXD_NACK);
        step(8'hA4, imtrs_pkg::STAT_REP_START);
        wr(imtrs_pkg::OFF_DATA, {SLV ^ 7'h01, 1'h1});
        step(8'h84, imtrs_pkg::STAT_RADDR_NACK);
        step(8'hB4, imtrs_pkg::STAT_START);
        rdChk(imtrs_pkg::OFF_CTRL, 8'hA4);
        $display("test transmit done");
    endtask : testTransmit

    task automatic testStop();
        logic [7:0] q;
        int t;
        wr(imtrs_pkg::OFF_DATA, {SLV, 1'h0});
        step(8'h84, imtrs_pkg::STAT_WADDR_ACK);
        wr(imtrs_pkg::OFF_DATA, 8'h3C);
        step(8'h84, imtrs_pkg::STAT_TXD_NACK);
        wr(imtrs_pkg::OFF_CTRL, 8'h94);
        t = 0;
        do begin
            bus(1'h0, imtrs_pkg::OFF_CTRL, 8'h00, q);
            t++;
        end while (q[4] !== 1'h0 && t < 2000);
        rdChk(imtrs_pkg::OFF_CTRL, 8'h04);
        rdChk(imtrs_pkg::OFF_STAT, imtrs_pkg::STAT_NONE);
        `CHK({sclOeN, sdaOeN}, 2'h3)
        $display("test stop done");
    endtask : testStop

    // A second master holds the data line low, so the first address bit is lost.
    task automatic arbLose();
        step(8'hA4, imtrs_pkg::STAT_START);
        wr(imtrs_pkg::OFF_DATA, {SLV, 1'h0});
        arbPull <= 1'h1;
        step(8'h84, imtrs_pkg::STAT_ARB_LOST);
        `CHK({sclOeN, sdaOeN}, 2'h3)
    endtask : arbLose

    // Letting the data line rise with the clock high is the STOP that frees the bus.
    task automatic testArb();
        arbLose();
        wr(imtrs_pkg::OFF_CTRL, 8'h84);
        repeat (300) @(posedge clk_sys);
        rdChk(imtrs_pkg::OFF_CTRL, 8'h04);
        `CHK({sclOeN, sdaOeN}, 2'h3)
        arbPull <= 1'h0;
        arbLose();
        wr(imtrs_pkg::OFF_CTRL, 8'hA4);
        repeat (300) @(posedge clk_sys);
        rdChk(imtrs_pkg::OFF_CTRL, 8'h24);
        `CHK({sclOeN, sdaOeN}, 2'h3)
        arbPull <= 1'h0;
        step(8'hA4, imtrs_pkg::STAT_START);
        $display("test arbitration done");
    endtask : testArb

    task automatic complete_run();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    // Main sequence: reset for six cycles, then the scenarios in turn.
    initial begin
        reset = 1'h1;
        avsRead = 1'h0;
        avsWrite = 1'h0;
        avsAddress = 4'h0;
        avsWritedata = 32'h0;
        avsByteenable = 4'hF;
        arbPull = 1'h0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'h0;
        testReset();
        testReceive();
        testTransmit();
        testStop();
        testArb();
        complete_run();
    end

    // Watchdog well beyond the expected length of about 42,000 cycles.
    initial begin
        #(25 * 90000);
        mismatches++;
        complete_run();
    end
endmodule : imtrs_top_test

/* File: logic/imtrs_pkg.sv */
// Shared constants and types of the two-wire master sequencer.
package imtrs_pkg;

    // Register byte offsets on the bus.
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STAT = 4'h4;
    localparam logic [3:0] OFF_DATA = 4'h8;

    // Bit positions inside the control register.
    localparam int CTRL_DONE_BIT = 7;
    localparam int CTRL_ACKEN_BIT = 6;
    localparam int CTRL_STA_BIT = 5;
    localparam int CTRL_STO_BIT = 4;
    localparam int CTRL_WC_BIT = 3;
    localparam int CTRL_EN_BIT = 2;

    // Status codes, prescaler bits taken as zero.
    localparam logic [7:0] STAT_START = 8'h08;
    localparam logic [7:0] STAT_REP_START = 8'h10;
    localparam logic [7:0] STAT_WADDR_ACK = 8'h18;
    localparam logic [7:0] STAT_WADDR_NACK = 8'h20;
    localparam logic [7:0] STAT_TXD_ACK = 8'h28;
    localparam logic [7:0] STAT_TXD_NACK = 8'h30;
    localparam logic [7:0] STAT_ARB_LOST = 8'h38;
    localparam logic [7:0] STAT_RADDR_ACK = 8'h40;
    localparam logic [7:0] STAT_RADDR_NACK = 8'h48;
    localparam logic [7:0] STAT_RXD_ACK = 8'h50;
    localparam logic [7:0] STAT_RXD_NACK = 8'h58;
    localparam logic [7:0] STAT_NONE = 8'hF8;

    // Reset values.
    localparam logic [7:0] DATA_RESET = 8'hFF;
    localparam logic [1:0] LINE_RESET = 2'h3;

    // Quarter of a bus bit period, and its length in system clocks.
    localparam int CLK_PERIOD_NS = 25;
    localparam int QUARTER_NS = 2500;
    localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_START,
        ST_BIT,
        ST_STOP,
        ST_HOLD
    } imtrs_state_t;

    typedef struct packed {
        logic done;
        logic ackEn;
        logic start_request_column;
        logic stop_request_column;
        logic wc;
        logic en;
    } imtrs_ctrl_t;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
    } imtrs_sync_t;

    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } imtrs_tick_t;

    typedef struct packed {
        imtrs_state_t state;
        logic [1:0]   qtr;
        logic [3:0]   bitCnt;
        logic [7:0]   shift;
        imtrs_ctrl_t  ctrl;
        logic [7:0]   status;
        logic [1:0]   presc;
        logic [7:0]   data;
        logic         busy;
        logic         sclPrev;
        logic         sdaPrev;
        logic         sclLow;
        logic         sdaLow;
        logic         addrPhase;
        logic         rxMode;
        logic         owner;
        logic         ackSeen;
        logic         waitReq;
        logic [7:0]   readData;
    } imtrs_core_t;

endpackage : imtrs_pkg

/* File: logic/imtrs_sync.sv */
// Two-flop synchroniser for the clock and data lines of the serial bus.
`timescale 1ns/100ps
module imtrs_sync (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [1:0] lineIn,
    output logic [1:0]      lineOut
);
    imtrs_pkg::imtrs_sync_t r;
    imtrs_pkg::imtrs_sync_t n;

    // The first stage feeds only the second; idle lines reset high.
    always_comb begin
        n = r;
        n.meta = lineIn;
        n.stable = r.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r <= {imtrs_pkg::LINE_RESET, imtrs_pkg::LINE_RESET};
        end else begin
            r <= n;
        end
    end

    assign lineOut = r.stable;
endmodule : imtrs_sync

/* File: logic/imtrs_tick.sv */
// Quarter-bit tick generator that paces the START, bit and STOP sequences.
`timescale 1ns/100ps
module imtrs_tick (
    input  wire logic clk_sys,
    input  wire logic reset,
    output logic      tick
);
    localparam logic [7:0] LAST = 8'(imtrs_pkg::QUARTER_CYC - 1);
    imtrs_pkg::imtrs_tick_t r;
    imtrs_pkg::imtrs_tick_t n;

    // Free running, so a quarter may start short after idle; harmless on an idle bus.
    always_comb begin
        n = r;
        n.tick = (r.count == LAST);
        n.count = n.tick ? 8'h00 : r.count + 8'h01;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;
endmodule : imtrs_tick

/* File: logic/imtrs_top.sv */
// Two-wire bus master sequencer with an Avalon-MM register slave.
`timescale 1ns/100ps
module imtrs_top (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        sclIn,
    output logic             sclOut,
    output logic             sclOeN,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOeN
);
    import imtrs_pkg::*;
    imtrs_core_t r;
    imtrs_core_t n;
    logic [1:0]  lines;
    logic        tick;
    logic        sclS;
    logic        sdaS;
    logic        kick;
    logic        advance;
    logic        rxByte;
    logic [7:0]  rdSel;

    imtrs_sync i_imtrs_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .lineIn  ({sclIn, sdaIn}),
        .lineOut (lines)
    );

    imtrs_tick i_imtrs_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick    (tick)
    );

    assign sclS = lines[1];
    assign sdaS = lines[0];

    // A quarter step waits in the sampling quarter while a slave stretches the clock.
    assign advance = tick && !(r.qtr == 2'd2 && !sclS);
    assign rxByte = r.rxMode && !r.addrPhase;

    always_comb begin
        n = r;
        kick = 1'b0;
        rdSel = 8'h00;
        // Bus busy tracking from START and STOP seen on the synchronised lines.
        n.sclPrev = sclS;
        n.sdaPrev = sdaS;
        if (sclS && r.sclPrev && r.sdaPrev && !sdaS) begin
            n.busy = 1'b1;
        end else if (sclS && r.sclPrev && !r.sdaPrev && sdaS) begin
            n.busy = 1'b0;
        end
        // Register slave: answer one cycle after the request, act at the taking edge.
        if (r.waitReq && (avs_read || avs_write)) begin
            n.waitReq = 1'b0;
            if (avs_address == OFF_CTRL) begin
                rdSel[CTRL_DONE_BIT] = r.ctrl.done;
                rdSel[CTRL_ACKEN_BIT] = r.ctrl.ackEn;
                rdSel[CTRL_STA_BIT] = r.ctrl.start_request_column;
                rdSel[CTRL_STO_BIT] = r.ctrl.stop_request_column;
                rdSel[CTRL_WC_BIT] = r.ctrl.wc;
                rdSel[CTRL_EN_BIT] = r.ctrl.en;
            end else if (avs_address == OFF_STAT) begin
                rdSel = {r.status[7:3], 1'b0, r.presc};
            end else if (avs_address == OFF_DATA) begin
                rdSel = r.data;
            end
            n.readData = rdSel;
        end else if (!r.waitReq) begin
            n.waitReq = 1'b1;
            if (avs_write && avs_byteenable[0]) begin
                if (avs_address == OFF_CTRL) begin
                    n.ctrl.en = avs_writedata[CTRL_EN_BIT];
                    n.ctrl.ackEn = avs_writedata[CTRL_ACKEN_BIT];
                    n.ctrl.start_request_column = avs_writedata[CTRL_STA_BIT];
                    n.ctrl.stop_request_column = avs_writedata[CTRL_STO_BIT];
                    if (avs_writedata[CTRL_DONE_BIT]) begin
                        n.ctrl.done = 1'b0;
                        kick = 1'b1;
                    end
                end else if (avs_address == OFF_STAT) begin
                    n.presc = avs_writedata[1:0];
                end else if (avs_address == OFF_DATA) begin
                    if (r.ctrl.done) begin
                        n.data = avs_writedata[7:0];
                        n.ctrl.wc = 1'b0;
                    end else begin
                        n.ctrl.wc = 1'b1;
                    end
                end
            end
        end
        // Sequencer; it runs after the slave so a hardware set of done wins a clear.
        case (r.state)
            ST_IDLE: begin
                if (kick && n.ctrl.start_request_column) begin
                    n.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!r.busy && tick) begin
                    n.state = ST_START;
                    n.qtr = 2'd0;
                end
            end
            ST_HOLD: begin
                if (kick) begin
                    n.qtr = 2'd0;
                    n.bitCnt = 4'h0;
                    if (r.status == STAT_ARB_LOST) begin
                        n.state = n.ctrl.start_request_column ? ST_WAIT : ST_IDLE;
                    end else if (r.rxMode && (r.status == STAT_RADDR_ACK
                                              || r.status == STAT_RXD_ACK)) begin
                        n.state = ST_BIT;
                    end else if (n.ctrl.stop_request_column) begin
                        n.state = ST_STOP;
                    end else if (n.ctrl.start_request_column) begin
                        n.state = ST_START;
                    end else begin
                        n.state = ST_BIT;
                        n.shift = n.data;
                        n.rxMode = r.addrPhase ? n.data[0] : 1'b0;
                    end
                end
            end
            ST_START: begin
                if (advance) begin
                    n.qtr = r.qtr + 2'd1;
                    if (r.qtr == 2'd0) begin
                        n.sdaLow = 1'b0;
                    end else if (r.qtr == 2'd1) begin
                        n.sclLow = 1'b0;
                    end else if (r.qtr == 2'd2) begin
                        n.sdaLow = 1'b1;
                    end else begin
                        n.sclLow = 1'b1;
                        n.ctrl.done = 1'b1;
                        n.status = r.owner ? STAT_REP_START : STAT_START;
                        n.owner = 1'b1;
                        n.addrPhase = 1'b1;
                        n.state = ST_HOLD;
                    end
                end
            end
            ST_BIT: begin
                if (advance) begin
                    n.qtr = r.qtr + 2'd1;
                    if (r.qtr == 2'd0) begin
                        n.sclLow = 1'b1;
                        if (r.bitCnt == 4'h8) begin
                            n.sdaLow = rxByte && r.ctrl.ackEn;
                        end else begin
                            n.sdaLow = !rxByte && !r.shift[7];
                        end
                    end else if (r.qtr == 2'd1) begin
                        n.sclLow = 1'b0;
                    end else if (r.qtr == 2'd2) begin
                        if (r.bitCnt == 4'h8) begin
                            n.ackSeen = !sdaS;
                        end else if (rxByte) begin
                            n.shift = {r.shift[6:0], sdaS};
                        end else if (!r.sdaLow && !sdaS) begin
                            // Another master drove low while we sent a one.
                            n.sclLow = 1'b0;
                            n.sdaLow = 1'b0;
                            n.owner = 1'b0;
                            n.ctrl.done = 1'b1;
                            n.status = STAT_ARB_LOST;
                            n.addrPhase = 1'b0;
                            n.state = ST_HOLD;
                        end else begin
                            n.shift = {r.shift[6:0], 1'b0};
                        end
                    end else begin
                        n.sclLow = 1'b1;
                        n.bitCnt = r.bitCnt + 4'h1;
                        if (r.bitCnt == 4'h8) begin
                            n.ctrl.done = 1'b1;
                            n.addrPhase = 1'b0;
                            n.state = ST_HOLD;
                            if (rxByte) begin
                                n.data = r.shift;
                                n.status = r.sdaLow ? STAT_RXD_ACK : STAT_RXD_NACK;
                            end else if (r.addrPhase && r.rxMode) begin
                                n.status = r.ackSeen ? STAT_RADDR_ACK : STAT_RADDR_NACK;
                            end else if (r.addrPhase) begin
                                n.status = r.ackSeen ? STAT_WADDR_ACK : STAT_WADDR_NACK;
                            end else begin
                                n.status = r.ackSeen ? STAT_TXD_ACK : STAT_TXD_NACK;
                            end
                        end
                    end
                end
            end
            ST_STOP: begin
                if (advance) begin
                    n.qtr = r.qtr + 2'd1;
                    if (r.qtr == 2'd0) begin
                        n.sclLow = 1'b1;
                        n.sdaLow = 1'b1;
                    end else if (r.qtr == 2'd1) begin
                        n.sclLow = 1'b0;
                    end else if (r.qtr == 2'd2) begin
                        n.sdaLow = 1'b0;
                    end else begin
                        n.ctrl.stop_request_column = 1'b0;
                        n.owner = 1'b0;
                        n.status = STAT_NONE;
                        n.state = n.ctrl.start_request_column ? ST_WAIT : ST_IDLE;
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        // Disabling the interface drops the bus at once, mid-byte or not.
        if (!n.ctrl.en) begin
            n.state = ST_IDLE;
            n.sclLow = 1'b0;
            n.sdaLow = 1'b0;
            n.owner = 1'b0;
        end
    end

    // Registered state; lines released and status idle after reset.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r <= '0;
            r.state <= ST_IDLE;
            r.status <= STAT_NONE;
            r.data <= DATA_RESET;
            r.sclPrev <= 1'b1;
            r.sdaPrev <= 1'b1;
            r.waitReq <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Open-drain pins only ever pull low, so the driven value is a constant zero.
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOeN = !r.sclLow;
    assign sdaOeN = !r.sdaLow;
    assign avs_readdata = {24'h000000, r.readData};
    assign avs_waitrequest = r.waitReq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_start_status;
        (r.state == ST_START && advance && r.qtr == 2'd3 && !r.owner)
            |=> r.ctrl.done && r.status == STAT_START;
    endproperty
    a_start_status: assert property (p_start_status) else $error("no 0x08 after START");

    property p_rep_start;
        (r.state == ST_START && advance && r.qtr == 2'd3 && r.owner)
            |=> r.owner && r.status == STAT_REP_START;
    endproperty
    a_rep_start: assert property (p_rep_start) else $error("no 0x10 after rep START");

    property p_collision;
        (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == OFF_DATA
         && !r.ctrl.done && r.state != ST_BIT) |=> r.ctrl.wc && $stable(r.data);
    endproperty
    a_collision: assert property (p_collision) else $error("collision write not dropped");

    property p_hold_low;
        (r.state == ST_HOLD && r.owner) |-> !sclOeN;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("clock released while done");

    property p_stop_clears;
        (r.state == ST_STOP && advance && r.qtr == 2'd3)
            |=> !r.ctrl.stop_request_column && !r.owner && sclOeN && sdaOeN;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop bit not cleared");

    property p_arb_lost;
        (r.state == ST_BIT && advance && r.qtr == 2'd2 && r.bitCnt != 4'h8 && !rxByte
         && !r.sdaLow && !sdaS) |=> r.status == STAT_ARB_LOST && sclOeN && sdaOeN;
    endproperty
    a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss missed");

    property p_wait_free;
        (r.state == ST_WAIT && r.busy) |=> r.state != ST_START;
    endproperty
    a_wait_free: assert property (p_wait_free) else $error("START on busy bus");

    property p_nack_resend;
        (r.state == ST_HOLD && r.status == STAT_TXD_NACK && kick && !n.ctrl.start_request_column
         && !n.ctrl.stop_request_column && n.ctrl.en) |=> r.state == ST_BIT && r.shift == $past(n.data);
    endproperty
    a_nack_resend: assert property (p_nack_resend) else $error("byte not resent");

    property p_rx_ack;
        (r.state == ST_BIT && rxByte && r.bitCnt == 4'h8 && r.qtr == 2'd1)
            |-> r.sdaLow == r.ctrl.ackEn;
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("wrong acknowledge driven");

    property p_rx_status;
        (r.state == ST_BIT && rxByte && advance && r.qtr == 2'd3 && r.bitCnt == 4'h8)
            |=> r.status == ($past(r.sdaLow) ? STAT_RXD_ACK : STAT_RXD_NACK)
                && r.data == $past(r.shift);
    endproperty
    a_rx_status: assert property (p_rx_status) else $error("bad receive status");

    property p_raddr_status;
        (r.state == ST_BIT && r.addrPhase && r.rxMode && advance && r.qtr == 2'd3
         && r.bitCnt == 4'h8) |=> r.status == STAT_RADDR_ACK || r.status == STAT_RADDR_NACK;
    endproperty
    a_raddr_status: assert property (p_raddr_status) else $error("bad read address status");

    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing wrong");

    c_read_byte: cover property (r.state == ST_BIT && rxByte ##[1:1000] r.status == STAT_RXD_NACK);
    c_arb: cover property (r.status == STAT_ARB_LOST);
    c_stop_start: cover property (r.state == ST_STOP ##[1:300] r.state == ST_WAIT);
endmodule : imtrs_top
